// ### burner_sequence_supervisor.sv
// burner sequencer and supervisor with flash-code lamp
`timescale 1ns/1ps
`default_nettype none
`include "burner_defines.svh"
module burner_sequence_supervisor #(
    parameter int TICK_CYCLES = `TICK_CYCLES // clocks per ms tick
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire burner_pkg::field_in_s fieldIn, // raw field pins
    input wire logic [2:0] nvmCause, // stored cause, pin level
    output burner_pkg::loads_s loads,
    output logic led,
    output logic nvmWe, // one-cycle write strobe
    output logic [2:0] nvmData,
    output logic [2:0] lockCause // cause now held
);
    burner_pkg::field_in_s meta_q, in_q; // two-flop synchroniser
    logic [2:0] nvmMeta_q, nvmIn_q; // stored cause synchroniser
    logic btnPrev_q; // button, one cycle old
    logic [17:0] div_q; // ms prescaler
    logic msTick; // one-cycle ms strobe
    burner_pkg::phase_e st_q, st_d; // sequence phase
    logic [16:0] ms_q; // ms spent in phase
    burner_pkg::cause_e cause_q, cause_d; // lockout cause
    logic retried_q; // quick retry already used
    logic booted_q; // stored cause looked at
    logic [11:0] hold_q; // button hold time, ms
    logic held; // button held long enough
    logic activeRun; // start-up or running phase
    logic airWatch; // air switch must stay closed
    logic btnRelease, btnPress;
    burner_pkg::flash_s code; // lamp code for this phase
    // flash code of each lockout cause
    function automatic burner_pkg::flash_s causeCode(
        input burner_pkg::cause_e c);
        case (c)
            burner_pkg::C_SAFETY: causeCode = {2'h0, 3'h5};
            burner_pkg::C_STRAY: causeCode = {2'h1, 3'h3};
            burner_pkg::C_AIRWELD: causeCode = {2'h1, 3'h4};
            burner_pkg::C_AIRTIMEOUT: causeCode = {2'h2, 3'h1};
            burner_pkg::C_AIROPEN: causeCode = {2'h2, 3'h2};
            burner_pkg::C_FLAMELOSS: causeCode = {2'h2, 3'h3};
            burner_pkg::C_MANUAL: causeCode = {2'h3, 3'h0};
            default: causeCode = {2'h0, 3'h0};
        endcase
    endfunction
    // pins cross into the clock domain through two flops
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= '0;
            in_q <= '0;
            // stored cause keeps syncing so the first tick sees it
            nvmMeta_q <= nvmCause;
            nvmIn_q <= nvmMeta_q;
            btnPrev_q <= 1'b0;
        end else if (ce) begin
            meta_q <= fieldIn;
            in_q <= meta_q;
            nvmMeta_q <= nvmCause;
            nvmIn_q <= nvmMeta_q;
            btnPrev_q <= in_q.button;
        end
    end
    assign btnPress = in_q.button && !btnPrev_q;
    assign btnRelease = !in_q.button && btnPrev_q;
    // millisecond tick prescaler
    always_ff @(posedge clk) begin
        if (rst) begin
            div_q <= 18'h0_0000;
        end else if (ce) begin
            div_q <= msTick ? 18'h0_0000 : div_q + 18'h0_0001;
        end
    end
    assign msTick = div_q >= 18'(TICK_CYCLES - 1);
    assign activeRun = (st_q == burner_pkg::WAITAIR) ||
        (st_q == burner_pkg::PREPURGE) || (st_q == burner_pkg::PREIGN) ||
        (st_q == burner_pkg::SAFETY) || (st_q == burner_pkg::STAGE2) ||
        (st_q == burner_pkg::RUN);
    assign airWatch = activeRun && (st_q != burner_pkg::WAITAIR);
    // button hold timer over start-up and running
    always_ff @(posedge clk) begin
        if (rst) begin
            hold_q <= 12'h000;
        end else if (ce) begin
            if (!in_q.button || !activeRun) begin
                hold_q <= 12'h000;
            end else if (msTick && !held) begin
                hold_q <= hold_q + 12'h001;
            end
        end
    end
    assign held = hold_q > 12'(`HOLD_MS);
    // next phase and cause
    always_comb begin
        st_d = st_q;
        cause_d = cause_q;
        case (st_q)
            // wait for demand; act on a tick so pins have settled
            burner_pkg::IDLE: begin
                if (msTick && !booted_q &&
                    nvmIn_q != burner_pkg::C_NONE) begin
                    st_d = burner_pkg::RECALL;
                end else if (msTick && booted_q && in_q.heatDemand) begin
                    // air switch must start open
                    st_d = in_q.airSwitch ? burner_pkg::QUICK
                                          : burner_pkg::WAITAIR;
                end
            end
            // fan briefly, then show the stored lockout
            burner_pkg::RECALL: begin
                if (ms_q >= 17'(`QUICK_FAN_MS)) begin
                    st_d = burner_pkg::LOCKOUT;
                    cause_d = burner_pkg::cause_e'(nvmIn_q);
                end
            end
            // fan briefly with closed air switch
            burner_pkg::QUICK: begin
                if (ms_q >= 17'(`QUICK_FAN_MS)) begin
                    if (retried_q && in_q.airSwitch) begin
                        st_d = burner_pkg::LOCKOUT;
                        cause_d = burner_pkg::C_AIRWELD;
                    end else begin
                        st_d = burner_pkg::QWAIT;
                    end
                end
            end
            // quick lockout, cleared after 10 s
            burner_pkg::QWAIT: begin
                if (ms_q >= 17'(`QUICK_RETRY_MS)) begin
                    st_d = burner_pkg::IDLE;
                end
            end
            // fan on, wait for the air switch
            burner_pkg::WAITAIR: begin
                if (in_q.airSwitch) begin
                    st_d = burner_pkg::PREPURGE;
                end else if (ms_q >= 17'(`AIR_PROVE_MS)) begin
                    st_d = burner_pkg::LOCKOUT;
                    cause_d = burner_pkg::C_AIRTIMEOUT;
                end
            end
            // supervised purge, stray light checked at its end
            burner_pkg::PREPURGE: begin
                if (in_q.flame && ms_q >=
                    17'(`PREPURGE_MS - `STRAY_WINDOW_MS)) begin
                    st_d = burner_pkg::LOCKOUT;
                    cause_d = burner_pkg::C_STRAY;
                end else if (ms_q >= 17'(`PREPURGE_MS)) begin
                    st_d = burner_pkg::PREIGN;
                end
            end
            burner_pkg::PREIGN: begin
                if (ms_q >= 17'(`PREIGNITION_MS)) begin
                    st_d = burner_pkg::SAFETY;
                end
            end
            // first valve open, flame needed by the end
            burner_pkg::SAFETY: begin
                if (ms_q >= 17'(`SAFETY_MS)) begin
                    if (in_q.flame) begin
                        st_d = burner_pkg::STAGE2;
                    end else begin
                        st_d = burner_pkg::LOCKOUT;
                        cause_d = burner_pkg::C_SAFETY;
                    end
                end
            end
            // first stage burning, second held back
            burner_pkg::STAGE2: begin
                if (ms_q >= 17'(`STAGE2_DELAY_MS)) begin
                    st_d = burner_pkg::RUN;
                end
            end
            burner_pkg::RUN: begin
                if (!in_q.heatDemand) begin
                    st_d = burner_pkg::IDLE;
                end
            end
            // held until a button press
            burner_pkg::LOCKOUT: begin
                if (btnPress) begin
                    st_d = burner_pkg::IDLE;
                    cause_d = burner_pkg::C_NONE;
                end
            end
            // supply low: wait, restart when it returns
            default: begin
                if (!in_q.mainsLow) begin
                    st_d = burner_pkg::IDLE;
                end
            end
        endcase
        // flame lost after it was proven: no restart
        if ((st_q == burner_pkg::STAGE2 || st_q == burner_pkg::RUN) &&
            !in_q.flame) begin
            st_d = burner_pkg::LOCKOUT;
            cause_d = burner_pkg::C_FLAMELOSS;
        end
        // air switch must stay closed once proven
        if (airWatch && !in_q.airSwitch) begin
            st_d = burner_pkg::LOCKOUT;
            cause_d = burner_pkg::C_AIROPEN;
        end
        // long press then release shuts down
        if (activeRun && btnRelease && held) begin
            st_d = burner_pkg::LOCKOUT;
            cause_d = burner_pkg::C_MANUAL;
        end
        // supply low overrides every phase but lockout
        if (in_q.mainsLow && st_q != burner_pkg::LOCKOUT) begin
            st_d = burner_pkg::LOWMAINS;
            cause_d = cause_q;
        end
    end
    // phase register and phase timer
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= burner_pkg::IDLE;
            ms_q <= 17'h0_0000;
        end else if (ce) begin
            st_q <= st_d;
            if (st_d != st_q) begin
                ms_q <= 17'h0_0000;
            end else if (msTick) begin
                ms_q <= ms_q + 17'h0_0001;
            end
        end
    end
    // cause, boot and retry bookkeeping; every change is stored
    always_ff @(posedge clk) begin
        if (rst) begin
            cause_q <= burner_pkg::C_NONE;
            booted_q <= 1'b0;
            retried_q <= 1'b0;
            nvmWe <= 1'b0;
            nvmData <= 3'h0;
        end else if (ce) begin
            cause_q <= cause_d;
            nvmWe <= cause_d != cause_q;
            nvmData <= cause_d;
            if (st_q == burner_pkg::IDLE && msTick) begin
                booted_q <= 1'b1;
            end
            // second try used up; cleared on a clean start
            if (st_q == burner_pkg::QWAIT) begin
                retried_q <= 1'b1;
            end else if (st_q == burner_pkg::WAITAIR ||
                         st_q == burner_pkg::LOCKOUT) begin
                retried_q <= 1'b0;
            end
        end
    end
    // load outputs, registered from the phase
    always_ff @(posedge clk) begin
        if (rst) begin
            loads <= '0;
        end else if (ce) begin
            loads.fan <= activeRun || st_q == burner_pkg::QUICK ||
                         st_q == burner_pkg::RECALL;
            // igniter off after the post-ignition interval
            loads.ignition <= st_q == burner_pkg::PREIGN ||
                (st_q == burner_pkg::SAFETY &&
                 ms_q < 17'(`POSTIGNITION_MS));
            loads.valve1 <= st_q == burner_pkg::SAFETY ||
                st_q == burner_pkg::STAGE2 || st_q == burner_pkg::RUN;
            loads.valve2 <= st_q == burner_pkg::RUN;
            // damper open first part of purge, then closes
            loads.damperOpen <= st_q == burner_pkg::RUN ||
                (st_q == burner_pkg::PREPURGE &&
                 ms_q < 17'(`DAMPER_OPEN_MS));
            loads.alarm <= st_q == burner_pkg::LOCKOUT;
        end
    end
    assign lockCause = cause_q;
    // lamp code per phase
    always_comb begin
        case (st_q)
            burner_pkg::WAITAIR: code = {2'h0, 3'h2};
            burner_pkg::PREPURGE: code = {2'h0, 3'h3};
            burner_pkg::PREIGN: code = {2'h0, 3'h4};
            burner_pkg::SAFETY: code = {2'h1, 3'h1};
            burner_pkg::STAGE2: code = {2'h1, 3'h2};
            burner_pkg::RUN: code = {2'h1, 3'h0};
            burner_pkg::LOWMAINS: code = {2'h2, 3'h0};
            burner_pkg::LOCKOUT: code = causeCode(cause_q);
            default: code = {2'h0, 3'h0};
        endcase
    end
    led_flasher lamp (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .msTick(msTick),
        .lockMode(st_q == burner_pkg::LOCKOUT),
        .code(code),
        .led(led)
    );
endmodule
`default_nettype wire

// ### burner_defines.svh
// timing and code constants for the burner sequence supervisor
`ifndef BURNER_DEFINES_SVH
`define BURNER_DEFINES_SVH
`define CLK_HZ 250000000
`define MS_PER_S 1000
// one millisecond tick, derived from the clock rate
`define TICK_CYCLES (`CLK_HZ / `MS_PER_S)
// sequence times in milliseconds
`define AIR_PROVE_MS 60000
`define PREPURGE_MS 44000
`define DAMPER_OPEN_MS 36000
`define DAMPER_CLOSE_MS 8000
`define PREIGNITION_MS 3000
`define POSTIGNITION_MS 2500
`define STRAY_WINDOW_MS 5000
`define SAFETY_MS 3000
`define STAGE2_DELAY_MS 6000
`define QUICK_FAN_MS 2500
`define QUICK_RETRY_MS 10000
`define HOLD_MS 3000
// lamp display times in milliseconds
`define LOCK_STEADY_MS 10000
`define LOCK_GAP_MS 600
`define LOCK_TAIL_MS 1200
`define PHASE_TAIL_MS 1000
`define SHORT_PULSE_MS 200
`define LONG_PULSE_MS 600
`define PULSE_PAUSE_MS 200
`endif

// ### burner_pkg.sv
// shared types of the burner sequence supervisor
package burner_pkg;
    // sequence phases, one-hot
    typedef enum logic [11:0] {
        IDLE = 12'h001,
        RECALL = 12'h002,
        QUICK = 12'h004,
        QWAIT = 12'h008,
        WAITAIR = 12'h010,
        PREPURGE = 12'h020,
        PREIGN = 12'h040,
        SAFETY = 12'h080,
        STAGE2 = 12'h100,
        RUN = 12'h200,
        LOCKOUT = 12'h400,
        LOWMAINS = 12'h800
    } phase_e;
    // lockout causes as kept in nonvolatile memory
    typedef enum logic [2:0] {
        C_NONE = 3'h0,
        C_SAFETY = 3'h1,
        C_STRAY = 3'h2,
        C_AIRWELD = 3'h3,
        C_AIRTIMEOUT = 3'h4,
        C_AIROPEN = 3'h5,
        C_FLAMELOSS = 3'h6,
        C_MANUAL = 3'h7
    } cause_e;
    // flash code: long pulses first, then short pulses
    typedef struct packed {
        logic [1:0] longs;
        logic [2:0] shorts;
    } flash_s;
    // field inputs, sampled together
    typedef struct packed {
        logic heatDemand;
        logic airSwitch;
        logic flame;
        logic mainsLow;
        logic button;
    } field_in_s;
    // burner load outputs
    typedef struct packed {
        logic fan;
        logic ignition;
        logic valve1;
        logic valve2;
        logic damperOpen;
        logic alarm;
    } loads_s;
endpackage

// ### led_flasher.sv
// lamp flash-code generator for phase and lockout display
`timescale 1ns/1ps
`default_nettype none
`include "burner_defines.svh"
module led_flasher (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic msTick,
    input wire logic lockMode,
    input wire burner_pkg::flash_s code,
    output logic led
);
    typedef enum logic [4:0] {
        F_STEADY = 5'h01,
        F_GAP = 5'h02,
        F_PULSE = 5'h04,
        F_PAUSE = 5'h08,
        F_TAIL = 5'h10
    } flash_e;
    flash_e st_q; // display step
    logic [13:0] ms_q; // ms spent in step
    burner_pkg::flash_s left_q; // pulses still to send
    logic tailDone; // end of dark tail
    logic [13:0] pulseLen; // length of current pulse
    // long pulses go out before short ones
    assign pulseLen = (left_q.longs != 2'h0) ? 14'(`LONG_PULSE_MS)
                                              : 14'(`SHORT_PULSE_MS);
    assign tailDone = ms_q >= (lockMode ? 14'(`LOCK_TAIL_MS - 1)
                                        : 14'(`PHASE_TAIL_MS - 1));
    // step sequencer, advances on millisecond ticks
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= F_TAIL;
            ms_q <= 14'h0000;
            left_q <= '0;
        end else if (ce && msTick) begin
            ms_q <= ms_q + 14'h0001;
            case (st_q)
                // lit steadily between lockout codes
                F_STEADY: begin
                    if (ms_q >= 14'(`LOCK_STEADY_MS) - 14'h0001) begin
                        st_q <= F_GAP;
                        ms_q <= 14'h0000;
                    end
                end
                // short dark gap before the cause code
                F_GAP: begin
                    if (ms_q >= 14'(`LOCK_GAP_MS) - 14'h0001) begin
                        st_q <= (left_q == '0) ? F_TAIL : F_PULSE;
                        ms_q <= 14'h0000;
                    end
                end
                // one lit pulse
                F_PULSE: begin
                    if (ms_q >= pulseLen - 14'h0001) begin
                        // no pause after the last pulse: tail follows
                        st_q <= ({2'h0, left_q.longs} +
                                 {1'b0, left_q.shorts} == 4'h1)
                                ? F_TAIL : F_PAUSE;
                        ms_q <= 14'h0000;
                        if (left_q.longs != 2'h0) begin
                            left_q.longs <= left_q.longs - 2'h1;
                        end else begin
                            left_q.shorts <= left_q.shorts - 3'h1;
                        end
                    end
                end
                // dark pause between pulses
                F_PAUSE: begin
                    if (ms_q >= 14'(`PULSE_PAUSE_MS) - 14'h0001) begin
                        st_q <= (left_q == '0) ? F_TAIL : F_PULSE;
                        ms_q <= 14'h0000;
                    end
                end
                // dark tail, then reload the code
                default: begin
                    if (tailDone) begin
                        ms_q <= 14'h0000;
                        left_q <= code;
                        if (lockMode) begin
                            st_q <= F_STEADY;
                        end else if (code != '0) begin
                            st_q <= F_PULSE;
                        end
                    end
                end
            endcase
        end
    end
    // lamp drive, registered
    always_ff @(posedge clk) begin
        if (rst) begin
            led <= 1'b0;
        end else if (ce) begin
            led <= (st_q == F_STEADY) || (st_q == F_PULSE);
        end
    end
endmodule
`default_nettype wire

// ### burner_sequence_supervisor_checker.sv
// assertion checker for the burner sequence supervisor
`timescale 1ns/1ps
`default_nettype none
module burner_sequence_supervisor_checker #(
    parameter int TICK_CYCLES = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire burner_pkg::field_in_s fieldIn,
    input wire logic [2:0] nvmCause,
    input wire burner_pkg::loads_s loads,
    input wire logic led,
    input wire logic nvmWe,
    input wire logic [2:0] nvmData,
    input wire logic [2:0] lockCause
);
    localparam int DAMP = 36000 * TICK_CYCLES; // damper open span
    logic [31:0] dampCnt_q; // cycles with fan and damper on
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (rst);
    // counts how long the damper stays open in pre-purge
    always_ff @(posedge clk) begin
        if (rst || !(loads.fan && loads.damperOpen)) begin
            dampCnt_q <= '0;
        end else begin
            dampCnt_q <= dampCnt_q + 32'h0000_0001;
        end
    end
    property p_damper;
        $fell(loads.damperOpen) && loads.fan |->
            dampCnt_q >= DAMP - 3 && dampCnt_q <= DAMP + 3;
    endproperty
    a_damper: assert property (p_damper)
        else $error("damper open time wrong");
    property p_lock_off;
        loads.alarm |-> !(loads.fan || loads.ignition || loads.valve1
            || loads.valve2);
    endproperty
    a_lock_off: assert property (p_lock_off)
        else $error("loads on during lockout");
    property p_nvm_data;
        nvmWe |-> nvmData == lockCause ##1 !nvmWe;
    endproperty
    a_nvm_data: assert property (p_nvm_data)
        else $error("store write wrong");
    property p_nvm_change;
        $changed(lockCause) |-> nvmWe;
    endproperty
    a_nvm_change: assert property (p_nvm_change)
        else $error("cause change not stored");
    property p_stage2;
        loads.valve2 |-> loads.valve1 && !loads.ignition;
    endproperty
    a_stage2: assert property (p_stage2)
        else $error("second stage out of order");
    property p_ign;
        $rose(loads.ignition) |-> loads.fan && !loads.valve1
            && !loads.damperOpen;
    endproperty
    a_ign: assert property (p_ign)
        else $error("ignition out of order");
    property p_safety;
        $rose(loads.valve1) |-> loads.ignition && !loads.valve2;
    endproperty
    a_safety: assert property (p_safety)
        else $error("first valve out of order");
    property p_airopen;
        $fell(fieldIn.airSwitch) && loads.fan && loads.damperOpen
            && !fieldIn.mainsLow && !fieldIn.button |->
            ##[2:6] loads.alarm && lockCause == burner_pkg::C_AIROPEN;
    endproperty
    a_airopen: assert property (p_airopen)
        else $error("air open not locked out");
    property p_flameloss;
        $fell(fieldIn.flame) && loads.valve2 && fieldIn.airSwitch
            && !fieldIn.mainsLow && !fieldIn.button |->
            ##[2:6] loads.alarm && lockCause == burner_pkg::C_FLAMELOSS;
    endproperty
    a_flameloss: assert property (p_flameloss)
        else $error("flame loss not locked out");
    property p_mains;
        $rose(fieldIn.mainsLow) && !loads.alarm |-> ##6 loads == 6'h00;
    endproperty
    a_mains: assert property (p_mains)
        else $error("low supply left loads on");
    c_stage2: cover property ($rose(loads.valve2));
    c_lock: cover property ($rose(loads.alarm));
    c_lamp: cover property (loads.alarm && $rose(led));
endmodule
`default_nettype wire

// ### field_equipment.sv
// field model: air switch, flame detector, nonvolatile cause store
`timescale 1ns/1ps
`default_nettype none
module field_equipment #(
    parameter int AIR_LAG = 50,
    parameter int FLAME_LAG = 200
) (
    input wire logic clk,
    input wire burner_pkg::loads_s loads,
    input wire logic airKill,
    input wire logic flameKill,
    input wire logic nvmWe,
    input wire logic [2:0] nvmData,
    output logic airSwitch,
    output logic flame,
    output logic [2:0] nvmCause
);
    int airCnt = 0; // blower run time
    int flameCnt = 0; // fuel on time
    logic [2:0] store = 3'h0; // survives reset of the device
    assign airSwitch = airCnt >= AIR_LAG && !airKill;
    assign flame = flameCnt >= FLAME_LAG && !flameKill;
    assign nvmCause = store;
    // air closes after the blower spins up, flame after fuel opens
    always @(negedge clk) begin
        if ((loads.fan || loads.valve1) && !airKill) begin
            airCnt <= airCnt < AIR_LAG ? airCnt + 1 : AIR_LAG;
        end else begin
            airCnt <= 0;
        end
        if (loads.valve1 && !flameKill) begin
            flameCnt <= flameCnt < FLAME_LAG ? flameCnt + 1 : FLAME_LAG;
        end else begin
            flameCnt <= 0;
        end
    end
    // stored cause written on each strobe
    always @(posedge clk) begin
        if (nvmWe) begin
            store <= nvmData;
        end
    end
endmodule
`default_nettype wire

// ### tb_burner_sequence_supervisor.sv
// testbench top for the burner sequence supervisor
`timescale 1ns/1ps
`default_nettype none
module tb_burner_sequence_supervisor;
    localparam int T = 1; // clocks per ms tick, shortened
    localparam int LED = 6, FAN = 5, IGN = 4, V1 = 3, V2 = 2, DMP = 1;
    localparam int ALM = 0;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, demand = 1'b0;
    logic mainsLow = 1'b0, button = 1'b0, airKill = 1'b0;
    logic flameKill = 1'b0, airSw, flameOn, nvmWe, led;
    logic [2:0] nvmCause, nvmData, lockCause;
    logic [6:0] outs;
    burner_pkg::loads_s loads;
    burner_pkg::field_in_s fieldIn;
    int n_errors = 0, tests_run = 0, cyc = 0, t0, t1, t2, t3, t4;
    logic [2:0] expQ[$]; // causes expected at the store
    assign fieldIn = {demand, airSw, flameOn, mainsLow, button};
    assign outs = {led, loads};
    always #2 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    burner_sequence_supervisor #(.TICK_CYCLES(T))
        burner_sequence_supervisor_inst (.clk(clk), .rst(rst), .ce(ce),
        .fieldIn(fieldIn), .nvmCause(nvmCause), .loads(loads), .led(led),
        .nvmWe(nvmWe), .nvmData(nvmData), .lockCause(lockCause));
    field_equipment field_equipment_inst (.clk(clk), .loads(loads),
        .airKill(airKill), .flameKill(flameKill), .nvmWe(nvmWe),
        .nvmData(nvmData), .airSwitch(airSw), .flame(flameOn),
        .nvmCause(nvmCause));
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(string name, int exp, int got, int tol);
        tests_run++;
        if (got < exp - tol || got > exp + tol) begin
            n_errors++;
            $display("MISMATCH %s expected %0d seen %0d", name, exp, got);
        end
    endtask
    task automatic check_bits(string name, logic [5:0] exp,
        logic [5:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    // bounded wait for one output bit
    task automatic wait_out(int k, logic v, int lim, output int t);
        int n;
        n = 0;
        while (outs[k] !== v && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (n >= lim) begin
            n_errors++;
            $display("MISMATCH output %0d expected %b seen timeout", k, v);
            final_report();
        end
        t = cyc;
    endtask
    task automatic press();
        button = 1'b1;
        repeat (20) @(negedge clk);
        button = 1'b0;
    endtask
    // store writes compared against the oldest note
    always @(negedge clk) begin
        if (!rst && nvmWe === 1'b1) begin
            if (expQ.size() == 0) begin
                check_bits("store write", 6'h3f, {3'h0, nvmData});
            end else begin
                check_bits("stored cause", {3'h0, expQ.pop_front()},
                    {3'h0, nvmData});
            end
        end
    end
    initial begin
        void'($urandom(99615));
        repeat (4) @(negedge clk);
        rst = 1'b0;
        demand = 1'b1;
        wait_out(DMP, 1'b1, 70000 * T, t0);
        wait_out(IGN, 1'b1, 50000 * T, t1);
        wait_out(V1, 1'b1, 5000 * T, t2);
        wait_out(IGN, 1'b0, 5000 * T, t3);
        wait_out(V2, 1'b1, 9000 * T, t4);
        check("prepurge", 44000 * T, t1 - t0, 3);
        check("preignition", 3000 * T, t2 - t1, 3);
        check("postignition", 2500 * T, t3 - t2, 3);
        check("stage two", 9000 * T, t4 - t2, 3);
        $display("test start-up done");
        expQ.push_back(burner_pkg::C_FLAMELOSS);
        repeat (100) @(negedge clk);
        flameKill = 1'b1;
        wait_out(ALM, 1'b1, 20, t0);
        check_bits("lockout loads", 6'h01, loads);
        repeat (2500 * T) @(negedge clk);
        wait_out(LED, 1'b0, 11000 * T, t1);
        wait_out(LED, 1'b1, 1000 * T, t2);
        wait_out(LED, 1'b0, 1000 * T, t3);
        check("lockout gap", 600 * T, t2 - t1, 2);
        check("first code pulse", 600 * T, t3 - t2, 2);
        repeat (4000 * T) @(negedge clk);
        wait_out(LED, 1'b0, 12000 * T, t4);
        check("lockout period", 14400 * T, t4 - t1, 4);
        $display("test flame loss done");
        flameKill = 1'b0;
        expQ.push_back(burner_pkg::C_NONE);
        press();
        wait_out(DMP, 1'b1, 3000 * T, t0);
        expQ.push_back(burner_pkg::C_AIROPEN);
        repeat ($urandom_range(2000, 100)) @(negedge clk);
        airKill = 1'b1;
        wait_out(ALM, 1'b1, 20, t0);
        airKill = 1'b0;
        $display("test air open done");
        repeat (500) @(negedge clk);
        expQ.push_back(burner_pkg::C_AIROPEN);
        rst = 1'b1;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        wait_out(FAN, 1'b1, 50, t0);
        wait_out(ALM, 1'b1, 3000 * T, t1);
        check("recall fan", 2500 * T, t1 - t0, 3);
        $display("test recall done");
        expQ.push_back(burner_pkg::C_NONE);
        repeat (300) @(negedge clk);
        press();
        wait_out(FAN, 1'b1, 3000 * T, t0);
        mainsLow = 1'b1;
        repeat ($urandom_range(3000, 500)) @(negedge clk);
        check_bits("low supply loads", 6'h00, loads);
        mainsLow = 1'b0;
        wait_out(FAN, 1'b1, 3000 * T, t0);
        expQ.push_back(burner_pkg::C_MANUAL);
        button = 1'b1;
        repeat (3100 * T) @(negedge clk);
        button = 1'b0;
        wait_out(ALM, 1'b1, 20, t0);
        check("pending writes", 0, expQ.size(), 0);
        $display("test low supply done");
        final_report();
    end
endmodule
bind burner_sequence_supervisor burner_sequence_supervisor_checker #(
    .TICK_CYCLES(TICK_CYCLES)
) burner_sequence_supervisor_checker_inst (.clk(clk), .rst(rst),
    .ce(ce), .fieldIn(fieldIn), .nvmCause(nvmCause), .loads(loads),
    .led(led), .nvmWe(nvmWe), .nvmData(nvmData), .lockCause(lockCause));
`default_nettype wire
